// ### hdl/dfcrc_top.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Bit 12 picks ROM or pattern RAM
// - Bits 6:4 set modulation level count
// - Bits 3:1 set dither LSB width
// - Dither off: no dither, RAM dark
// - RAM access needs four enables set
// - Six-bit RAM row address field
// - Data access with RAM open increments row address
// - Full 32-bit word per RAM access
// - CRC polynomial 1+x3+x4+x24, 24 bits
// - Modulation test signature repeats per 64
// - Signature 31:8, frame index 7:2
// - Free-run sampled at frame start
// - Free-run low stops after frame
// - Signature bit 0 enables capture
// - Panel type steers data, unused zero
// - Panel word is CRC input
// - RAM 32 columns by 64 rows
// - Dither MSB set inverts pattern data
module dfcrc_top
	import dfcrc_pkg::*;
#(
	parameter int ROWS = DFCRC_ROWS,
	parameter int COLS = DFCRC_COLS
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic reg_ack,
	input wire logic [2:0] panel_type,
	input wire logic [5:0] pat_row,
	input wire logic [4:0] pat_col,
	input wire logic [4:0] dither_bits,
	output logic pattern_bit,
	input wire dfcrc_pix_t pix_in,
	output logic [23:0] panel_data,
	output logic dither_on,
	output logic ram_powerdown,
	output logic [2:0] level_count,
	output logic [2:0] dither_width
);
	// ==========================================
	// State
	typedef struct packed {
		dfcrc_ctrl_t ctrl;
		dfcrc_ramctl_t ramctl;
		logic [31:0] rdata;
		logic ack;
		logic sig_en;
		logic free_run;
		logic [23:0] crc;
		logic [23:0] sig;
		logic [5:0] frame_idx;
		dfcrc_state_t state;
		logic [23:0] pdata;
		logic pbit;
		logic pvalid;
		logic psof;
	} dfcrc_st_t;

	dfcrc_st_t st_ff;
	dfcrc_st_t nxt_st;
	logic [COLS-1:0] ram_mem [ROWS];
	logic [23:0] crc_next;
	logic ram_open;
	logic ram_wr;
	logic ram_rd;
	logic [COLS-1:0] ram_q;
	logic [23:0] steered;
	logic sel_ctrl;
	logic sel_ramctl;
	logic sel_ramdat;
	logic sel_sig;
	logic pat_ram_bit;

	// ==========================================
	// Helpers
	function automatic logic ram_allowed(dfcrc_ctrl_t c, dfcrc_ramctl_t r);
		return r.access & r.update & c.src_ram & c.enable;
	endfunction

	// Width code to dither MSB position (5 bits at code 1 down to 1 bit at code 5)
	function automatic logic dither_msb(logic [2:0] wid, logic [4:0] bits);
		logic [2:0] n;
		n = DFCRC_WID_MAX - wid;
		if (wid == DFCRC_WID_RSVD || wid > DFCRC_WID_MAX) begin
			return 1'b0;
		end
		return bits[n];
	endfunction

	// Fixed ROM pattern: simple ordered pattern, replaced by RAM when selected
	function automatic logic rom_bit(logic [5:0] row, logic [4:0] col);
		return row[0] ^ row[3] ^ col[0];
	endfunction

	// Frame index wraps after 64 captures, so signatures repeat with it
	function automatic logic [5:0] next_index(logic [5:0] idx);
		if (idx == DFCRC_FRAME_WRAP) begin
			return 6'h00;
		end
		return idx + 6'h01;
	endfunction

	assign ram_open = ram_allowed(st_ff.ctrl, st_ff.ramctl);
	assign ram_wr = reg_wr && sel_ramdat && ram_open;
	assign ram_rd = reg_rd && sel_ramdat && ram_open;
	assign ram_q = ram_mem[st_ff.ramctl.addr];
	// Pixel lookup uses its own row, independent of the software access pointer
	assign pat_ram_bit = ram_mem[pat_row][pat_col];

	dfcrc_crc24 u_crc (
		.crc_in(st_ff.crc),
		.data_in(panel_data),
		.crc_out(crc_next)
	);

	// ==========================================
	// Register decode
	always_comb begin
		sel_ctrl = 1'b0;
		sel_ramctl = 1'b0;
		sel_ramdat = 1'b0;
		sel_sig = 1'b0;
		if (reg_addr == DFCRC_OFS_CTRL) begin
			sel_ctrl = 1'b1;
		end else if (reg_addr == DFCRC_OFS_RAMCTL) begin
			sel_ramctl = 1'b1;
		end else if (reg_addr == DFCRC_OFS_RAMDAT) begin
			sel_ramdat = 1'b1;
		end else if (reg_addr == DFCRC_OFS_SIG) begin
			sel_sig = 1'b1;
		end
	end

	// ==========================================
	// Pattern RAM: bit n of the word is column n
	always_ff @(posedge clk) begin
		if (ram_wr) begin
			ram_mem[st_ff.ramctl.addr] <= reg_wdata[COLS-1:0];
		end
	end

	// ==========================================
	// Panel steering; narrow types use only the mapped lanes
	always_comb begin
		steered = 24'h000000;
		if (panel_type == DFCRC_PT_DSTN24) begin
			steered = pix_in.word;
		end else if (panel_type == DFCRC_PT_DSTN16) begin
			steered = pix_in.word & DFCRC_MASK_DSTN16;
		end else if (panel_type == DFCRC_PT_SSTN8) begin
			steered = pix_in.word & DFCRC_MASK_SSTN8;
		end
		if (!pix_in.valid) begin
			steered = 24'h000000;
		end
	end

	// ==========================================
	// Next state
	always_comb begin
		nxt_st = st_ff;
		nxt_st.ack = reg_wr | reg_rd;
		nxt_st.pdata = steered;
		// Qualifiers travel with the registered word, so the CRC folds what the pins show
		nxt_st.pvalid = pix_in.valid;
		nxt_st.psof = pix_in.valid & pix_in.sof;
		if (reg_wr) begin
			if (sel_ctrl) begin
				nxt_st.ctrl.src_ram = reg_wdata[DFCRC_B_SRCSEL];
				nxt_st.ctrl.level_count = reg_wdata[6:4];
				nxt_st.ctrl.dither_width = reg_wdata[3:1];
				nxt_st.ctrl.enable = reg_wdata[DFCRC_B_ENABLE];
			end else if (sel_ramctl) begin
				nxt_st.ramctl.access = reg_wdata[DFCRC_B_ACCESS];
				nxt_st.ramctl.update = reg_wdata[DFCRC_B_UPDATE];
				nxt_st.ramctl.addr = reg_wdata[5:0];
			end else if (sel_sig) begin
				nxt_st.sig_en = reg_wdata[DFCRC_B_SIGEN];
				nxt_st.free_run = reg_wdata[DFCRC_B_FREERUN];
			end
		end
		if (ram_wr || ram_rd) begin
			nxt_st.ramctl.addr = st_ff.ramctl.addr + 6'h01;
		end
		if (reg_rd) begin
			if (sel_ctrl) begin
				nxt_st.rdata = {19'h00000, st_ff.ctrl.src_ram, 5'h00,
					st_ff.ctrl.level_count, st_ff.ctrl.dither_width, st_ff.ctrl.enable};
			end else if (sel_ramctl) begin
				nxt_st.rdata = {24'h000000, st_ff.ramctl};
			end else if (sel_ramdat) begin
				// RAM stays dark while closed, so read data is zero then
				nxt_st.rdata = ram_open ? ram_q : 32'h00000000;
			end else if (sel_sig) begin
				nxt_st.rdata = {st_ff.sig, st_ff.frame_idx, st_ff.free_run,
					st_ff.sig_en};
			end else begin
				nxt_st.rdata = 32'h00000000;
			end
		end
		// Signature sequencer
		case (st_ff.state)
			DFCRC_IDLE: begin
				if (st_ff.psof && st_ff.sig_en && st_ff.free_run) begin
					nxt_st.crc = DFCRC_SEED;
					nxt_st.state = DFCRC_RUN;
				end
			end
			DFCRC_RUN: begin
				if (st_ff.psof) begin
					nxt_st.sig = st_ff.crc;
					nxt_st.frame_idx = next_index(st_ff.frame_idx);
					nxt_st.crc = DFCRC_SEED;
					if (!st_ff.free_run || !st_ff.sig_en) begin
						nxt_st.state = DFCRC_IDLE;
					end
				end else begin
					if (st_ff.pvalid) begin
						nxt_st.crc = crc_next;
					end
					// A falling free-run bit lets the frame in progress finish first
					if (!st_ff.free_run || !st_ff.sig_en) begin
						nxt_st.state = DFCRC_LAST;
					end
				end
			end
			DFCRC_LAST: begin
				if (st_ff.psof) begin
					nxt_st.sig = st_ff.crc;
					nxt_st.frame_idx = next_index(st_ff.frame_idx);
					nxt_st.crc = DFCRC_SEED;
					if (st_ff.free_run && st_ff.sig_en) begin
						nxt_st.state = DFCRC_RUN;
					end else begin
						nxt_st.state = DFCRC_IDLE;
					end
				end else if (st_ff.pvalid) begin
					nxt_st.crc = crc_next;
				end
			end
			default: begin
				nxt_st.state = DFCRC_IDLE;
			end
		endcase
		// Pattern lookup, inverted by the dither MSB
		if (st_ff.ctrl.enable) begin
			nxt_st.pbit = (st_ff.ctrl.src_ram ? pat_ram_bit : rom_bit(pat_row, pat_col))
				^ dither_msb(st_ff.ctrl.dither_width, dither_bits);
		end else begin
			nxt_st.pbit = 1'b0;
		end
	end

	// ==========================================
	// Registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_ff.ctrl <= dfcrc_ctrl_t'(DFCRC_RST_WORD[7:0]);
			st_ff.ramctl <= dfcrc_ramctl_t'(DFCRC_RST_WORD[7:0]);
			st_ff.rdata <= DFCRC_RST_WORD;
			st_ff.ack <= 1'b0;
			st_ff.sig_en <= 1'b0;
			st_ff.free_run <= 1'b0;
			st_ff.crc <= DFCRC_SEED;
			st_ff.sig <= DFCRC_SEED;
			st_ff.frame_idx <= 6'h00;
			st_ff.state <= DFCRC_IDLE;
			st_ff.pdata <= 24'h000000;
			st_ff.pbit <= 1'b0;
			st_ff.pvalid <= 1'b0;
			st_ff.psof <= 1'b0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ==========================================
	// Outputs
	assign reg_rdata = st_ff.rdata;
	assign reg_ack = st_ff.ack;
	assign panel_data = st_ff.pdata;
	assign pattern_bit = st_ff.pbit;
	assign dither_on = st_ff.ctrl.enable;
	assign ram_powerdown = ~ram_open;
	assign level_count = st_ff.ctrl.level_count;
	// Width has no effect while dithering is off
	assign dither_width = st_ff.ctrl.enable ? st_ff.ctrl.dither_width : 3'h0;
endmodule

// ### hdl/dfcrc_pkg.sv
package dfcrc_pkg;
	// ==========================================
	// Register map
	localparam logic [11:0] DFCRC_OFS_CTRL = 12'h40c;
	localparam logic [11:0] DFCRC_OFS_RAMCTL = 12'h424;
	localparam logic [11:0] DFCRC_OFS_RAMDAT = 12'h428;
	localparam logic [11:0] DFCRC_OFS_SIG = 12'h42c;
	localparam logic [31:0] DFCRC_RST_WORD = 32'h00000000;
	// ==========================================
	// Field positions
	localparam int DFCRC_B_ENABLE = 0;
	localparam int DFCRC_B_SRCSEL = 12;
	localparam int DFCRC_B_ACCESS = 7;
	localparam int DFCRC_B_UPDATE = 6;
	localparam int DFCRC_B_SIGEN = 0;
	localparam int DFCRC_B_FREERUN = 1;
	localparam logic [2:0] DFCRC_WID_RSVD = 3'h0;
	localparam logic [2:0] DFCRC_WID_MAX = 3'h5;
	localparam logic [2:0] DFCRC_LVL_MAX = 3'h4;
	localparam logic [2:0] DFCRC_PT_DSTN16 = 3'h1;
	localparam logic [2:0] DFCRC_PT_DSTN24 = 3'h2;
	localparam logic [2:0] DFCRC_PT_SSTN8 = 3'h3;
	// Pins that carry data per narrow panel type; every other pin stays zero
	localparam logic [23:0] DFCRC_MASK_DSTN16 = 24'hfcfcf0;
	localparam logic [23:0] DFCRC_MASK_SSTN8 = 24'h003cf0;
	// CRC taps 1 + x^3 + x^4 + x^24
	localparam logic [23:0] DFCRC_POLY = 24'h000019;
	localparam logic [23:0] DFCRC_SEED = 24'h000000;
	localparam logic [5:0] DFCRC_FRAME_WRAP = 6'h3f;
	localparam int DFCRC_ROWS = 64;
	localparam int DFCRC_COLS = 32;
	// ==========================================
	// Types
	typedef struct packed {
		logic src_ram;
		logic [2:0] level_count;
		logic [2:0] dither_width;
		logic enable;
	} dfcrc_ctrl_t;
	typedef struct packed {
		logic access;
		logic update;
		logic [5:0] addr;
	} dfcrc_ramctl_t;
	typedef struct packed {
		logic valid;
		logic sof;
		logic [23:0] word;
	} dfcrc_pix_t;
	typedef enum logic [2:0] {
		DFCRC_IDLE = 3'b001,
		DFCRC_RUN = 3'b010,
		DFCRC_LAST = 3'b100
	} dfcrc_state_t;
endpackage

// ### hdl/dfcrc_crc24.sv
`timescale 1ns/1ns
module dfcrc_crc24
	import dfcrc_pkg::*;
(
	input wire logic [23:0] crc_in,
	input wire logic [23:0] data_in,
	output logic [23:0] crc_out
);
	// Serial LFSR unrolled over the 24 data bits, MSB first
	always_comb begin
		logic [23:0] c;
		c = crc_in;
		for (int i = 23; i >= 0; i--) begin
			if (c[23] ^ data_in[i]) begin
				c = {c[22:0], 1'b0} ^ DFCRC_POLY;
			end else begin
				c = {c[22:0], 1'b0};
			end
		end
		crc_out = c;
	end
endmodule

// ### dv/dfcrc_checker.sv
`timescale 1ns/1ns
module dfcrc_checker
	import dfcrc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic reg_ack,
	input wire logic [2:0] panel_type,
	input wire dfcrc_pix_t pix_in,
	input wire logic [23:0] panel_data,
	input wire logic dither_on,
	input wire logic ram_powerdown,
	input wire logic [2:0] dither_width,
	input wire logic pattern_bit
);
	// ==========================================
	// Port relations
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	ack_follows_a: assert property ((reg_wr || reg_rd) |=> reg_ack) else $error("no ack");
	ack_cause_a: assert property (reg_ack |-> $past(reg_wr || reg_rd)) else $error("stray ack");
	ram_dark_a: assert property (!dither_on |-> ram_powerdown) else $error("ram awake");
	width_off_a: assert property (!dither_on |-> dither_width == 3'h0) else $error("width on");
	pattern_off_a: assert property (!dither_on |=> !pattern_bit) else $error("pattern on");
	idle_zero_a: assert property (!pix_in.valid |=> panel_data == 24'h0) else $error("idle");
	bad_type_a: assert property (!(panel_type inside {3'h1, 3'h2, 3'h3}) |=> panel_data == 24'h0)
		else $error("bad type");
	narrow_wide_a: assert property (panel_type == 3'h1 |=> (panel_data & 24'h03030f) == 24'h0)
		else $error("dstn16 pins");
	narrow_byte_a: assert property (panel_type == 3'h3 |=> (panel_data & 24'hffc30f) == 24'h0)
		else $error("sstn8 pins");
	cover property (reg_ack && !ram_powerdown);
	cover property (pix_in.sof && panel_type == 3'h2);
	cover property (pix_in.valid && panel_type == 3'h3);
endmodule
bind dfcrc_top dfcrc_checker dfcrc_checker_i (.*);

// ### dv/dfcrc_pix_src.sv
`timescale 1ns/1ns
module dfcrc_pix_src
	import dfcrc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic go,
	input wire logic stall,
	input wire logic [23:0] base,
	input wire logic [7:0] n,
	output dfcrc_pix_t pix_in,
	output logic busy
);
	// ==========================================
	// Frame source
	// Start word is zero so the result does not hang on when the clear lands
	logic [8:0] i_ff;
	assign busy = i_ff != 9'h0;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			i_ff <= 9'h0;
			pix_in <= '0;
		end else if (busy && !stall) begin
			pix_in <= {1'b1, i_ff == 9'h1, i_ff == 9'h1 ? 24'h0 : base + 24'(i_ff - 9'h1)};
			i_ff <= i_ff > {1'b0, n} ? 9'h0 : i_ff + 9'h1;
		end else begin
			pix_in <= {2'b00, ~pix_in.word};
			if (go)
				i_ff <= 9'h1;
		end
	end
endmodule

// ### dv/dfcrc_bench.sv
`timescale 1ns/1ns
module dfcrc_bench
	import dfcrc_pkg::*;
;
	logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, reg_ack, pattern_bit, dither_on, ram_powerdown;
	logic go = 0, stall = 0, busy;
	logic [11:0] reg_addr = '0;
	logic [31:0] reg_wdata = '0, reg_rdata, q, seed = 34, w[3];
	logic [2:0] panel_type = 3'h2, level_count, dither_width, pt[4] = '{1, 3, 0, 7};
	logic [5:0] pat_row = '0;
	logic [4:0] pat_col = '0, dither_bits = '0;
	logic [23:0] panel_data, base = '0, cr, ca, cb;
	logic [7:0] n = '0;
	logic [11:0] regs[4] = '{DFCRC_OFS_CTRL, DFCRC_OFS_RAMCTL, DFCRC_OFS_RAMDAT, 12'h7fc};
	dfcrc_pix_t pix_in;
	int miscompares = 0, checked = 0, cyc = 0;
	dfcrc_top dfcrc_top_i (.*);
	dfcrc_pix_src dfcrc_pix_src_i (.*);
	always #25 clk = ~clk;
	// ==========================================
	// Helpers
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function logic [23:0] fcrc(input logic [23:0] b, input int k);
		logic [23:0] c;
		logic [23:0] d;
		c = DFCRC_SEED;
		for (int i = 1; i <= k; i++) begin
			d = b + 24'(i);
			for (int j = 23; j >= 0; j--)
				c = {c[22:0], 1'b0} ^ ((c[23] ^ d[j]) ? DFCRC_POLY : 24'h0);
		end
		return c;
	endfunction
	task chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask
	// Strobe is one cycle wide, so it drops 5 ns after the answer edge
	task acc(input logic wr, input logic [11:0] a, input logic [31:0] d);
		reg_wr = wr;
		reg_rd = !wr;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clk);
		#5;
		reg_wr = 0;
		reg_rd = 0;
		chk(reg_ack, 1);
		q = reg_rdata;
		@(posedge clk);
		#5;
	endtask
	task frame(input logic [7:0] k);
		base = 24'(rnd());
		n = k;
		go = 1;
		@(posedge clk);
		#5;
		go = 0;
		wait (!busy);
		repeat (3) @(posedge clk);
		#5;
		cr = fcrc(base, k);
	endtask
	task close_out();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge clk) #5 stall = rnd() % 4 == 0;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			close_out();
		end
	end
	// ==========================================
	// Sequence
	initial begin
		repeat (20) @(posedge clk);
		#5;
		rst = 0;
		foreach (regs[i]) begin
			acc(0, regs[i], 0);
			chk(q, DFCRC_RST_WORD);
		end
		chk(ram_powerdown, 1);
		for (int k = 5; k >= 1; k--) begin
			acc(1, DFCRC_OFS_CTRL, {19'h0, 1'b1, 5'h0, 3'(k - 1), 3'(k), 1'b1});
			chk(dither_width, k);
			chk(level_count, k - 1);
			acc(0, DFCRC_OFS_CTRL, 0);
			chk(q, 32'h1001 | (k - 1) << 4 | k << 1);
		end
		acc(1, DFCRC_OFS_CTRL, 0);
		chk(dither_width, 0);
		acc(1, DFCRC_OFS_RAMCTL, 32'hc5);
		acc(1, DFCRC_OFS_RAMDAT, rnd());
		acc(0, DFCRC_OFS_RAMDAT, 0);
		chk(q, 0);
		acc(0, DFCRC_OFS_RAMCTL, 0);
		chk(q, 32'hc5);
		acc(1, DFCRC_OFS_CTRL, 32'h1003);
		chk(ram_powerdown, 0);
		acc(1, DFCRC_OFS_RAMCTL, 32'hfe);
		foreach (w[i]) begin
			w[i] = rnd();
			acc(1, DFCRC_OFS_RAMDAT, w[i]);
		end
		acc(0, DFCRC_OFS_RAMCTL, 0);
		chk(q, 32'hc1);
		acc(1, DFCRC_OFS_RAMCTL, 32'hfe);
		foreach (w[i]) begin
			acc(0, DFCRC_OFS_RAMDAT, 0);
			chk(q, w[i]);
		end
		pat_row = 6'h3f;
		for (int j = 0; j < 64; j++) begin
			pat_col = 5'(j);
			dither_bits = j >= 32 ? 5'h10 : 5'h0;
			@(posedge clk);
			@(posedge clk);
			#5;
			chk(pattern_bit, w[1][j % 32] ^ (j >= 32));
		end
		foreach (pt[i]) begin
			panel_type = pt[i];
			frame(4);
		end
		panel_type = 3'h2;
		acc(1, DFCRC_OFS_SIG, 32'h1);
		frame(6);
		frame(6);
		acc(0, DFCRC_OFS_SIG, 0);
		chk(q, 32'h1);
		acc(1, DFCRC_OFS_SIG, 32'h3);
		frame(8);
		ca = cr;
		frame(5);
		cb = cr;
		acc(0, DFCRC_OFS_SIG, 0);
		chk(q, {ca, 6'h1, 2'h3});
		frame(7);
		ca = cr;
		acc(0, DFCRC_OFS_SIG, 0);
		chk(q, {cb, 6'h2, 2'h3});
		acc(1, DFCRC_OFS_SIG, 32'h1);
		frame(4);
		frame(4);
		acc(0, DFCRC_OFS_SIG, 0);
		chk(q, {ca, 6'h3, 2'h1});
		close_out();
	end
endmodule
